// ### ovs_defs.svh
// constants for the overload and fault supervision block
// assumes a 50 MHz clock; load levels are in 0.1 % of nominal
`ifndef OVS_DEFS_SVH
`define OVS_DEFS_SVH
`define OVS_CLK_HZ          50000000
`define OVS_TICK_MS         100
`define OVS_TICK_CYCLES     (`OVS_TICK_MS * (`OVS_CLK_HZ / 1000))
`define OVS_MS_CYCLES       (`OVS_CLK_HZ / 1000)
`define OVS_LOAD_THRESHOLD  16'h041A
`define OVS_TRIP_COUNT      32'h0000_2710
`define OVS_DUTY_MAX        8'h96
`define OVS_PERCENT_FULL    8'h64
`define OVS_ACT_NONE        2'h0
`define OVS_ACT_WARN        2'h1
`define OVS_ACT_FAULT       2'h2
`define OVS_SRC_OFF         2'h0
`define OVS_SRC_CURRENT     2'h1
`define OVS_SRC_TORQUE      2'h2
`define OVS_SRC_POWER       2'h3
`define OVS_SIM_OVERCURRENT 0
`define OVS_SIM_OVERVOLTAGE 1
`define OVS_SIM_UNDERVOLT   2
`define OVS_SIM_PHASE_LOSS  3
`define OVS_SIM_EARTH       4
`define OVS_SIM_SYSTEM      5
`define OVS_SIM_ENCODER     6
`define OVS_SIM_TEMP_WARN   7
`define OVS_SIM_TEMP_FAULT  8
`define OVS_SIM_RESERVED    9
`define OVS_LOG_BLOCK       2'h3
`define OVS_LOG_RESET       2'h1
`endif

// ### ovs_pkg.sv
// types shared by the overload and fault supervision files
// assumes ovs_defs.svh for the numeric codes
package ovs_pkg;
  typedef logic [15:0] ovs_level_t;
  typedef struct packed {
    logic link_watchdog;
    logic link_slot_e;
    logic link_slot_d;
    logic overload;
    logic overtemp;
    logic encoder;
    logic system;
    logic earth;
    logic phase_loss;
    logic undervoltage;
    logic overvoltage;
    logic overcurrent;
  } ovs_fault_s;
  typedef struct packed {
    ovs_level_t current;
    ovs_level_t torque;
    ovs_level_t power;
  } ovs_load_s;
endpackage

// ### ovs_ramp.sv
// slope scaling for the overload accumulator step
// assumes level inputs in 0.1 % of nominal, same clock as the caller
`include "ovs_defs.svh"
module ovs_ramp (
  input  wire logic              clk,
  input  wire logic              reset,
  input  wire ovs_pkg::ovs_level_t level,
  input  wire ovs_pkg::ovs_level_t full_scale,
  input  wire ovs_pkg::ovs_level_t full_inc,
  output logic                   above,
  output logic                   below,
  output ovs_pkg::ovs_level_t    step
);
  import ovs_pkg::*;

  wire logic        up_w    = level > `OVS_LOAD_THRESHOLD;
  wire logic        dn_w    = level < `OVS_LOAD_THRESHOLD;
  wire logic [15:0] diff_w  = up_w ? 16'(level - `OVS_LOAD_THRESHOLD)
                                   : 16'(`OVS_LOAD_THRESHOLD - level);
  wire logic [15:0] span_w  = 16'(full_scale - `OVS_LOAD_THRESHOLD);
  wire logic        flat_w  = full_scale <= `OVS_LOAD_THRESHOLD;
  wire logic [31:0] prod_w  = diff_w * full_inc;
  // zero at the threshold, full_inc at full scale, linear between
  wire logic [31:0] quot_w  = flat_w ? {16'h0000, full_inc} : prod_w / {16'h0000, span_w};
  // clamped beyond full scale so a huge overload cannot wrap the step
  wire logic [15:0] step_w  = (quot_w > {16'h0000, full_inc}) ? full_inc : quot_w[15:0];

  always_ff @(posedge clk) begin
    if (reset) begin
      above <= 1'b0;
      below <= 1'b0;
      step  <= 16'h0000;
    end else begin
      above <= up_w;
      below <= dn_w;
      step  <= step_w;
    end
  end
endmodule // ovs_ramp

// ### ovs_top.sv
// overload accumulator, fault responses, link watchdog, fault simulation
// assumes all inputs except link_pulse are on clk; link_pulse is a pin
//
// Behaviour
// - every 100 ms raise accumulator above 105 %, lower it below
// - overload trip when accumulator exceeds ten thousand counts
// - step linear from zero at 105 % to maximum at full scale
// - overload action: 0 none, 1 warning, 2 fault
// - source: 0 off, 1 current, 2 torque, 3 power
// - per slot link fault response only when fieldbus controls
// - fault when watchdog pulse missing for delay; zero disables
// - simulation bits 0 to 6 inject the named faults
// - simulated fault looks exactly like the real one outside
// - bit 7 temp warning, bit 8 fault needs bit 7 or real warning
// - datalogger command: -1 blocked, 0 nothing, 1 reset
// - duty cycle 0 to 150 % sets thermal nominal current point
`include "ovs_defs.svh"
module ovs_top #(
  parameter int TICK_CYCLES = `OVS_TICK_CYCLES,
  parameter int MS_CYCLES   = `OVS_MS_CYCLES,
  parameter int ACC_W       = 16
) (
  input  wire logic                clk,
  input  wire logic                reset,
  input  wire ovs_pkg::ovs_load_s  load_in,
  input  wire logic [1:0]          overload_source_select,
  input  wire logic [1:0]          overload_action_select,
  input  wire ovs_pkg::ovs_level_t overload_full_scale_level,
  input  wire ovs_pkg::ovs_level_t overload_full_scale_increment,
  input  wire ovs_pkg::ovs_fault_s real_fault,
  input  wire logic                real_temp_warning,
  input  wire ovs_pkg::ovs_level_t drive_temperature,
  input  wire ovs_pkg::ovs_level_t temp_warning_level,
  input  wire logic                control_place_fieldbus,
  input  wire logic                link_fault_slot_d,
  input  wire logic                link_fault_slot_e,
  input  wire logic [1:0]          slot_d_action_select,
  input  wire logic [1:0]          slot_e_action_select,
  input  wire logic                link_pulse,
  input  wire logic [15:0]         link_pulse_timeout,
  input  wire logic [9:0]          fault_sim_word,
  input  wire logic [1:0]          datalog_command,
  input  wire logic [7:0]          motor_duty_cycle,
  input  wire ovs_pkg::ovs_level_t motor_nominal_current,
  output ovs_pkg::ovs_fault_s      fault_out,
  output ovs_pkg::ovs_fault_s      warning_out,
  output logic                     drive_fault_state,
  output logic [ACC_W-1:0]         overload_count,
  output logic                     overload_trip,
  output logic                     datalog_reset,
  output logic                     datalog_blocked,
  output ovs_pkg::ovs_level_t      thermal_nominal_current
);
  import ovs_pkg::*;

  ////////////////////////////////////////////////////////////////////
  // shared decode

  function automatic logic [1:0] act_decode(input logic [1:0] sel, input logic ev);
    act_decode = {ev && (sel == `OVS_ACT_FAULT), ev && (sel == `OVS_ACT_WARN)};
  endfunction

  ////////////////////////////////////////////////////////////////////
  // 100 ms tick

  logic [31:0] tick_cnt_reg;
  logic [31:0] tick_cnt_next;
  wire  logic  tick_w = tick_cnt_reg == 32'(TICK_CYCLES - 1);
  assign tick_cnt_next = tick_w ? 32'h0000_0000 : 32'(tick_cnt_reg + 32'h0000_0001);

  always_ff @(posedge clk) begin
    if (reset) tick_cnt_reg <= 32'h0000_0000;
    else       tick_cnt_reg <= tick_cnt_next;
  end

  ////////////////////////////////////////////////////////////////////
  // overload accumulator

  wire ovs_level_t sel_level_w =
    (overload_source_select == `OVS_SRC_CURRENT) ? load_in.current :
    (overload_source_select == `OVS_SRC_TORQUE)  ? load_in.torque  :
    (overload_source_select == `OVS_SRC_POWER)   ? load_in.power   : 16'h0000;
  wire logic src_off_w = overload_source_select == `OVS_SRC_OFF;

  logic       ramp_above;
  logic       ramp_below;
  ovs_level_t ramp_step;

  ovs_ramp u_ramp (
    .clk        (clk),
    .reset      (reset),
    .level      (sel_level_w),
    .full_scale (overload_full_scale_level),
    .full_inc   (overload_full_scale_increment),
    .above      (ramp_above),
    .below      (ramp_below),
    .step       (ramp_step)
  );

  localparam logic [ACC_W:0] ACC_MAX = {1'b0, {ACC_W{1'b1}}};
  logic [ACC_W-1:0] acc_reg;
  logic [ACC_W-1:0] acc_next;
  wire  logic [ACC_W:0] step_ext_w = (ACC_W + 1)'(ramp_step);
  wire  logic [ACC_W:0] sum_w      = {1'b0, acc_reg} + step_ext_w;
  wire  logic [ACC_W-1:0] inc_w    = (sum_w > ACC_MAX) ? ACC_MAX[ACC_W-1:0] : sum_w[ACC_W-1:0];
  // never wraps under zero during long light load
  wire  logic [ACC_W-1:0] dec_w    = ({1'b0, acc_reg} < step_ext_w) ? '0
                                   : ACC_W'({1'b0, acc_reg} - step_ext_w);

  always_comb begin
    acc_next = acc_reg;
    if (src_off_w)                acc_next = '0;
    else if (tick_w && ramp_above) acc_next = inc_w;
    else if (tick_w && ramp_below) acc_next = dec_w;
  end

  wire logic trip_w = 32'(acc_reg) > `OVS_TRIP_COUNT;
  wire logic [1:0] ol_act_w = act_decode(overload_action_select, trip_w);

  ////////////////////////////////////////////////////////////////////
  // link fault responses and watchdog

  // slot faults only matter while the fieldbus is the active control place
  wire logic [1:0] slot_d_w = act_decode(slot_d_action_select,
                                         link_fault_slot_d && control_place_fieldbus);
  wire logic [1:0] slot_e_w = act_decode(slot_e_action_select,
                                         link_fault_slot_e && control_place_fieldbus);

  logic pulse_meta_reg;
  logic pulse_sync_reg;
  logic pulse_prev_reg;
  wire  logic pulse_edge_w = pulse_sync_reg && !pulse_prev_reg;

  logic [31:0] ms_cnt_reg;
  wire  logic  ms_w = ms_cnt_reg == 32'(MS_CYCLES - 1);
  logic [15:0] miss_ms_reg;
  logic [15:0] miss_ms_next;
  wire  logic  wd_on_w = link_pulse_timeout != 16'h0000;
  wire  logic  wd_fault_w = wd_on_w && (miss_ms_reg >= link_pulse_timeout);
  // ms grid restarts at each pulse, so a miss is timed from the pulse and never fires early
  wire  logic  ms_clr_w   = ms_w || pulse_edge_w || !wd_on_w;

  always_comb begin
    miss_ms_next = miss_ms_reg;
    if (pulse_edge_w || !wd_on_w)           miss_ms_next = 16'h0000;
    else if (ms_w && miss_ms_reg != 16'hFFFF) miss_ms_next = 16'(miss_ms_reg + 16'h0001);
  end

  ////////////////////////////////////////////////////////////////////
  // fault simulation and merge

  wire logic sim_temp_warn_w = fault_sim_word[`OVS_SIM_TEMP_WARN];
  // the fault bit alone arms a fault at the real warning level
  wire logic real_at_warn_w  = real_temp_warning || (drive_temperature >= temp_warning_level);
  wire logic sim_temp_flt_w  = fault_sim_word[`OVS_SIM_TEMP_FAULT]
                             && (sim_temp_warn_w || real_at_warn_w);

  ovs_fault_s fault_w;
  ovs_fault_s warn_w;
  always_comb begin
    fault_w = real_fault;
    fault_w.overcurrent  = real_fault.overcurrent  || fault_sim_word[`OVS_SIM_OVERCURRENT];
    fault_w.overvoltage  = real_fault.overvoltage  || fault_sim_word[`OVS_SIM_OVERVOLTAGE];
    fault_w.undervoltage = real_fault.undervoltage || fault_sim_word[`OVS_SIM_UNDERVOLT];
    fault_w.phase_loss   = real_fault.phase_loss   || fault_sim_word[`OVS_SIM_PHASE_LOSS];
    fault_w.earth        = real_fault.earth        || fault_sim_word[`OVS_SIM_EARTH];
    fault_w.system       = real_fault.system       || fault_sim_word[`OVS_SIM_SYSTEM];
    fault_w.encoder      = real_fault.encoder      || fault_sim_word[`OVS_SIM_ENCODER];
    fault_w.overtemp     = real_fault.overtemp     || sim_temp_flt_w;
    fault_w.overload     = ol_act_w[1];
    fault_w.link_slot_d  = slot_d_w[1];
    fault_w.link_slot_e  = slot_e_w[1];
    fault_w.link_watchdog = wd_fault_w;
    warn_w = '0;
    warn_w.overtemp    = real_temp_warning || sim_temp_warn_w;
    warn_w.overload    = ol_act_w[0];
    warn_w.link_slot_d = slot_d_w[0];
    warn_w.link_slot_e = slot_e_w[0];
  end

  ////////////////////////////////////////////////////////////////////
  // datalogger command and duty cycle

  logic [1:0] log_prev_reg;
  wire  logic log_block_w = datalog_command == `OVS_LOG_BLOCK;
  wire  logic log_fire_w  = (datalog_command == `OVS_LOG_RESET)
                         && (log_prev_reg != `OVS_LOG_RESET);

  // out-of-range settings are held at the limit rather than ignored
  wire logic [7:0]  duty_w  = (motor_duty_cycle > `OVS_DUTY_MAX) ? `OVS_DUTY_MAX
                                                                 : motor_duty_cycle;
  wire logic [23:0] therm_w = (motor_nominal_current * duty_w) / `OVS_PERCENT_FULL;

  ////////////////////////////////////////////////////////////////////
  // registers

  always_ff @(posedge clk) begin
    if (reset) begin
      acc_reg        <= '0;
      pulse_meta_reg <= 1'b0;
      pulse_sync_reg <= 1'b0;
      pulse_prev_reg <= 1'b0;
      ms_cnt_reg     <= 32'h0000_0000;
      miss_ms_reg    <= 16'h0000;
      log_prev_reg   <= 2'h0;
    end else begin
      acc_reg        <= acc_next;
      pulse_meta_reg <= link_pulse;
      pulse_sync_reg <= pulse_meta_reg;
      pulse_prev_reg <= pulse_sync_reg;
      ms_cnt_reg     <= ms_clr_w ? 32'h0000_0000 : 32'(ms_cnt_reg + 32'h0000_0001);
      miss_ms_reg    <= miss_ms_next;
      log_prev_reg   <= datalog_command;
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      fault_out               <= '0;
      warning_out             <= '0;
      drive_fault_state       <= 1'b0;
      overload_count          <= '0;
      overload_trip           <= 1'b0;
      datalog_reset           <= 1'b0;
      datalog_blocked         <= 1'b0;
      thermal_nominal_current <= 16'h0000;
    end else begin
      fault_out               <= fault_w;
      warning_out             <= warn_w;
      drive_fault_state       <= |fault_w;
      overload_count          <= acc_reg;
      overload_trip           <= trip_w;
      datalog_reset           <= log_fire_w;
      datalog_blocked         <= log_block_w;
      thermal_nominal_current <= therm_w[15:0];
    end
  end
endmodule // ovs_top

// ### ovs_sva.sv
// port checker for ovs_top, attached to every instance by bind
// assumes synchronous active-high reset and one clock
`include "ovs_defs.svh"
module ovs_sva #(
  parameter int ACC_W = 16
) (
  input wire logic                clk,
  input wire logic                reset,
  input wire logic [1:0]          overload_source_select,
  input wire logic [ACC_W-1:0]    overload_count,
  input wire logic                overload_trip,
  input wire ovs_pkg::ovs_fault_s fault_out,
  input wire ovs_pkg::ovs_fault_s warning_out,
  input wire logic                drive_fault_state,
  input wire logic [15:0]         link_pulse_timeout,
  input wire logic                control_place_fieldbus,
  input wire logic [9:0]          fault_sim_word,
  input wire logic [1:0]          datalog_command,
  input wire logic                datalog_reset,
  input wire logic                datalog_blocked,
  input wire logic [7:0]          motor_duty_cycle,
  input wire ovs_pkg::ovs_level_t motor_nominal_current,
  input wire ovs_pkg::ovs_level_t thermal_nominal_current
);
  import ovs_pkg::*;
  // duty clamped first, so an oversized setting cannot overstate the current
  wire logic [23:0] thr_calc = motor_nominal_current *
    (motor_duty_cycle > `OVS_DUTY_MAX ? `OVS_DUTY_MAX : motor_duty_cycle) / `OVS_PERCENT_FULL;
  default clocking @(posedge clk); endclocking
  default disable iff (reset);
  ////////////////////////////////////////
  a_trip_count: assert property (overload_trip == (overload_count > `OVS_TRIP_COUNT))
    else $error("trip flag disagrees with count");
  a_count_hold: assert property ($changed(overload_count) && overload_source_select != 2'h0 |=>
    ($stable(overload_count) || overload_count == 0)[*8]) else $error("count moved between ticks");
  a_src_clear: assert property (overload_source_select == 2'h0 |-> ##2 overload_count == 0)
    else $error("count not cleared with source off");
  a_trip_cause: assert property (fault_out.overload || warning_out.overload |-> overload_trip)
    else $error("overload indication without trip");
  a_wdog_off: assert property ((link_pulse_timeout == 16'h0000)[*4] |-> !fault_out.link_watchdog)
    else $error("watchdog fault with supervision off");
  a_slot_gate: assert property (!control_place_fieldbus |=> !(fault_out.link_slot_d ||
    fault_out.link_slot_e || warning_out.link_slot_d || warning_out.link_slot_e))
    else $error("slot response while fieldbus not in control");
  a_sim_inject: assert property (!$past(reset) |=>
    (fault_out[6:0] & $past(fault_sim_word[6:0])) == $past(fault_sim_word[6:0]))
    else $error("simulated fault missing");
  a_fault_state: assert property (drive_fault_state == (|fault_out))
    else $error("fault state disagrees with faults");
  a_temp_warn: assert property (!$past(reset) && fault_sim_word[7] |=> warning_out.overtemp)
    else $error("simulated temperature warning missing");
  a_log_pulse: assert property (datalog_reset |-> $past(datalog_command) == 2'h1 &&
    !$past(datalog_reset)) else $error("datalog reset pulse without command");
  a_log_block: assert property (!$past(reset) && datalog_command == 2'h3 |=> datalog_blocked)
    else $error("datalog block missing");
  a_thermal_scale: assert property (!$past(reset) |=>
    thermal_nominal_current == $past(thr_calc[15:0])) else $error("thermal current wrong");
endmodule // ovs_sva
bind ovs_top ovs_sva #(.ACC_W(ACC_W)) u_sva (.*);

// ### ovs_link_master.sv
// fieldbus master model that sends watchdog pulses on the link pin
// assumes the pin is sampled through a synchroniser; period is unrelated to clk
module ovs_link_master (
  input  wire logic run,
  output logic      pulse
);
  timeunit 1ns;
  timeprecision 1ps;
  // pin idles low; pulses last two clock periods so the synchroniser catches them
  initial begin
    pulse = 1'b0;
    forever begin
      // odd times keep the rising pin edges off the clock edges
      #91;
      pulse = run;
      #43;
      pulse = 1'b0;
    end
  end
endmodule // ovs_link_master

// ### ovs_top_bench.sv
// self-checking bench for ovs_top with shortened tick counts
// assumes ovs_sva is bound in and ovs_link_master drives the link pin
`include "ovs_defs.svh"
module ovs_top_bench;
  timeunit 1ns;
  timeprecision 1ps;
  import ovs_pkg::*;
  logic        clk = 1'b0;
  logic        reset = 1'b1;
  ovs_load_s   load_in;
  logic [1:0]  overload_source_select, overload_action_select, datalog_command;
  logic [1:0]  slot_d_action_select, slot_e_action_select;
  ovs_level_t  overload_full_scale_level, overload_full_scale_increment;
  ovs_level_t  drive_temperature, temp_warning_level;
  ovs_level_t  motor_nominal_current, thermal_nominal_current;
  ovs_fault_s  real_fault, fault_out, warning_out;
  logic        real_temp_warning, control_place_fieldbus, link_fault_slot_d, link_fault_slot_e;
  logic        link_pulse, run, drive_fault_state, overload_trip, datalog_reset, datalog_blocked;
  logic [15:0] link_pulse_timeout, overload_count;
  logic [9:0]  fault_sim_word;
  logic [7:0]  motor_duty_cycle;
  int          err_total = 0, samples_checked = 0, cyc = 0;
  ovs_top #(.TICK_CYCLES(20), .MS_CYCLES(5)) u_dut (.*);
  ovs_link_master u_master (.run(run), .pulse(link_pulse));
  initial begin
    forever #10 clk = ~clk;
  end
  ////////////////////////////////////////
  task automatic finish_test;
    $display("checked %0d mismatches %0d", samples_checked, err_total);
    if (err_total == 0 && samples_checked > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask
  task automatic chk(input string what, input logic [15:0] seen, exp);
    samples_checked++;
    if (seen !== exp) begin
      err_total++;
      $display("BAD %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic wait_n(input int n);
    repeat (n) @(negedge clk);
  endtask
  // called mid-way between ticks so the new step is registered before the next tick
  task automatic ovl(input logic [1:0] s, input ovs_level_t c, t, p, input int n, ovs_level_t e);
    overload_source_select = s;
    load_in = '{c, t, p};
    wait_n(20 * n);
    chk("overload count", overload_count, e);
  endtask
  task automatic sim_case(input logic [9:0] w, input logic [15:0] ef, ew);
    fault_sim_word = w;
    wait_n(2);
    chk("sim fault", fault_out, ef);
    chk("sim warn", warning_out, ew);
    chk("fault state", drive_fault_state, |ef);
  endtask
  ////////////////////////////////////////
  task automatic test_overload;
    int i;
    for (i = 0; i < 40 && overload_count === 16'h0000; i++) begin
      wait_n(1);
    end
    wait_n(10);
    chk("first step", overload_count, 16'h002D);
    ovl(2'h1, 16'h04FB, 16'h0000, 16'h0000, 221, 16'h2706);
    chk("trip low", overload_trip, 1'b0);
    ovl(2'h1, 16'h04FB, 16'h0000, 16'h0000, 1, 16'h2733);
    chk("trip high", overload_trip, 1'b1);
    for (i = 0; i < 4; i++) begin
      overload_action_select = 2'(i);
      wait_n(5);
      chk("trip fault", fault_out.overload, i == 2);
      chk("trip warn", warning_out.overload, i == 1);
    end
    ovl(2'h0, 16'h04FB, 16'h0000, 16'h0000, 1, 16'h0000);
    ovl(2'h3, 16'h05DC, 16'h05DC, 16'h03E8, 1, 16'h0000);
    ovl(2'h3, 16'h0000, 16'h0000, 16'h05DC, 1, 16'h005A);
    ovl(2'h3, 16'h05DC, 16'h05DC, 16'h02BC, 1, 16'h0014);
    ovl(2'h3, 16'h05DC, 16'h05DC, 16'h02BC, 1, 16'h0000);
    ovl(2'h2, 16'h0000, 16'h05DC, 16'h0000, 1, 16'h005A);
    ovl(2'h2, 16'h05DC, `OVS_LOAD_THRESHOLD, 16'h05DC, 1, 16'h005A);
    ovl(2'h1, 16'h07D0, 16'h0000, 16'h0000, 1, 16'h00B4);
    overload_source_select = 2'h0;
    overload_action_select = `OVS_ACT_NONE;
    wait_n(3);
  endtask
  task automatic test_sim;
    for (int i = 0; i < 7; i++) begin
      fault_sim_word = 10'h001 << i;
      wait_n(2);
      chk("sim fault", fault_out, 16'h0001 << i);
      chk("fault state", drive_fault_state, 1'b1);
      fault_sim_word = 10'h000;
      real_fault = 12'h001 << i;
      wait_n(2);
      chk("real fault", fault_out, 16'h0001 << i);
      real_fault = '0;
    end
    sim_case(10'h200, 16'h0000, 16'h0000);
    sim_case(10'h080, 16'h0000, 16'h0080);
    sim_case(10'h100, 16'h0000, 16'h0000);
    sim_case(10'h180, 16'h0080, 16'h0080);
    real_temp_warning = 1'b1;
    sim_case(10'h100, 16'h0080, 16'h0080);
    real_temp_warning = 1'b0;
    fault_sim_word = 10'h100;
    drive_temperature = 16'h0100;
    wait_n(2);
    chk("temp fault", fault_out, 16'h0080);
    fault_sim_word = 10'h000;
    drive_temperature = 16'h0050;
    wait_n(2);
  endtask
  task automatic test_slots;
    {control_place_fieldbus, link_fault_slot_d, link_fault_slot_e} = 3'h7;
    for (int i = 0; i < 3; i++) begin
      slot_d_action_select = 2'(i);
      slot_e_action_select = 2'(2 - i);
      wait_n(2);
      chk("slot fault", fault_out, i == 2 ? 16'h0200 : i == 0 ? 16'h0400 : 16'h0000);
      chk("slot warn", warning_out, i == 1 ? 16'h0600 : 16'h0000);
    end
    control_place_fieldbus = 1'b0;
    wait_n(2);
    chk("slot off", fault_out | warning_out, 16'h0000);
  endtask
  task automatic test_watchdog;
    link_pulse_timeout = 16'h0002;
    wait_n(40);
    chk("watchdog miss", fault_out, 16'h0800);
    run = 1'b1;
    wait_n(40);
    chk("watchdog fed", fault_out, 16'h0000);
    run = 1'b0;
    link_pulse_timeout = 16'h0000;
    wait_n(40);
    chk("watchdog off", fault_out, 16'h0000);
  endtask
  task automatic test_log;
    datalog_command = 2'h1;
    wait_n(1);
    chk("log reset", datalog_reset, 1'b1);
    wait_n(1);
    chk("log once", datalog_reset, 1'b0);
    datalog_command = 2'h3;
    wait_n(1);
    chk("log block", {datalog_blocked, datalog_reset}, 16'h0002);
    datalog_command = 2'h0;
    wait_n(1);
    chk("log idle", {datalog_blocked, datalog_reset}, 16'h0000);
  endtask
  task automatic test_thermal;
    logic [7:0] d [4] = '{8'h82, 8'h96, 8'hC8, 8'h00};
    logic [15:0] e [4] = '{16'h0514, 16'h05DC, 16'h05DC, 16'h0000};
    for (int i = 0; i < 4; i++) begin
      motor_duty_cycle = d[i];
      wait_n(2);
      chk("thermal current", thermal_nominal_current, e[i]);
    end
  endtask
  ////////////////////////////////////////
  // ceiling is about two and a half times the length of the longest sequence
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 12000) begin
      err_total++;
      finish_test();
    end
  end
  initial begin
    load_in = '{16'h04FB, 16'h0000, 16'h0000};
    overload_source_select = 2'h1;
    overload_action_select = `OVS_ACT_FAULT;
    overload_full_scale_level = 16'h05DC;
    overload_full_scale_increment = 16'h005A;
    real_fault = '0;
    {real_temp_warning, control_place_fieldbus, link_fault_slot_d, link_fault_slot_e, run} = '0;
    {slot_d_action_select, slot_e_action_select, datalog_command} = '0;
    drive_temperature = 16'h0050;
    temp_warning_level = 16'h0100;
    link_pulse_timeout = 16'h0000;
    fault_sim_word = 10'h000;
    motor_duty_cycle = 8'h00;
    motor_nominal_current = 16'h03E8;
    wait_n(3);
    reset = 1'b0;
    test_overload();
    test_sim();
    test_slots();
    test_watchdog();
    test_log();
    test_thermal();
    finish_test();
  end
endmodule // ovs_top_bench
